// ### logic/lintmc_pkg.sv
// package: constants and state encoding for the lin transceiver mode controller
package lintmc_pkg;
   // clock rate and filter times (microseconds)
   localparam int CLK_MHZ = 40;
   localparam int T_ENABLE_US = 10;
   localparam int T_DISABLE_US = 10;
   localparam int T_WAKE_US = 50;
   localparam int T_LIN_WAKE_US = 50;
   // filter counts in clock cycles, least times rounded up
   localparam int N_ENABLE = T_ENABLE_US * CLK_MHZ;
   localparam int N_DISABLE = T_DISABLE_US * CLK_MHZ;
   localparam int N_WAKE = T_WAKE_US * CLK_MHZ;
   localparam int N_LIN_WAKE = T_LIN_WAKE_US * CLK_MHZ;
   localparam int CNT_W = 16;
   // values after reset
   localparam logic RST_PD_STRONG = 1'b0;
   localparam logic RST_WAKE_IND = 1'b0;
   // one-hot operating states
   typedef enum logic [3:0] {
      ST_UNPOWERED = 4'h1,
      ST_STANDBY = 4'h2,
      ST_NORMAL = 4'h4,
      ST_SLEEP = 4'h8
   } lintmc_state_t;
   // wake-up kind reported
   typedef enum logic [1:0] {
      WK_NONE = 2'h0,
      WK_BUS = 2'h1,
      WK_LOCAL = 2'h2
   } lintmc_wake_t;
endpackage

// ### logic/lintmc_filter.sv
// module: qualification counter, asserts done once level held for limit cycles
`timescale 1ns/1ps
module lintmc_filter #(
   parameter logic [15:0] LIMIT = 16'h0190
) (
   // clocking
   input wire logic clock,
   input wire logic nrst,
   input wire logic clkEn,
   // level under test and result
   input wire logic active,
   output logic done
);
   logic [15:0] cnt_ff;
   logic [15:0] nxt_cnt;
   wire atLimit = (cnt_ff >= LIMIT);
   // counter saturates so done stays high while the level holds
   assign nxt_cnt = !active ? 16'h0000 : (atLimit ? cnt_ff : cnt_ff + 16'h0001);
   assign done = atLimit;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst)
         cnt_ff <= 16'h0000;
      else if (clkEn)
         cnt_ff <= nxt_cnt;
   end
endmodule

// ### logic/lintmc_top.sv
// module: operating-state controller of a single-wire lin transceiver
// Overview of operation
// - receive output low while bus dominant in normal
// - mode-select high requests normal; pulled low
// - local alert falling edge is wake source
// - transmit low sends dominant; switchable pull-down
// - regulator switch output controls external regulator
// - thermal shutdown disables the transmitter
// - four states from supply, mode, alert, bus
// - unpowered: all released, weak pull-down only
// - supply below reset level forces unpowered
// - standby: transceiver off, regulator switch on
// - power-up standby: receive released, pull-down weak
// - wake-up standby: receive output pulled low
// - bus wake weak, local wake strong pull-down
// - standby configuration fixed until mode-select high, later wakes ignored
// - normal after mode-select high past filter
// - sleep after mode-select low past filter
// - local wake: fall then low past filter
// - bus wake: dominant past filter, then rise
`timescale 1ns/1ps
module lintmc_top #(
   parameter int N_ENABLE = lintmc_pkg::N_ENABLE,
   parameter int N_DISABLE = lintmc_pkg::N_DISABLE,
   parameter int N_WAKE = lintmc_pkg::N_WAKE,
   parameter int N_LIN_WAKE = lintmc_pkg::N_LIN_WAKE
) (
   // clocking
   input wire logic clock,
   input wire logic nrst,
   input wire logic clkEn,
   // supply and protection monitors
   input wire logic batterySupplyOk,
   input wire logic thermalShutdown,
   // host pins
   input wire logic modeSelect,
   input wire logic txData,
   output logic rxDataOut,
   output logic rxDataOe,
   output logic txPullStrong,
   // local alert and bus
   input wire logic localAlert,
   input wire logic busDominant,
   output logic busDriveDominant,
   output logic busTermOn,
   // regulator switch and status
   output logic regulatorSwitchOut,
   output logic [3:0] opState,
   output logic [1:0] wakeKind
);
   lintmc_pkg::lintmc_state_t state_ff, nxt_state;
   lintmc_pkg::lintmc_wake_t wake_ff, nxt_wake;
   logic alertPrev_ff, busPrev_ff, wakeArmed_ff, txSeenHigh_ff, stbEnSeen_ff;
   logic enHeld, disHeld, alertHeld, busHeld, busHeldLat_ff;
   // one-hot state test, shared by decode and pin logic
   function automatic logic inState(input lintmc_pkg::lintmc_state_t cur,
      input lintmc_pkg::lintmc_state_t want);
      return cur == want;
   endfunction
   // local wake wins when both kinds qualify in the same cycle
   function automatic lintmc_pkg::lintmc_wake_t wakeSel(input logic isLocal);
      return isLocal ? lintmc_pkg::WK_LOCAL : lintmc_pkg::WK_BUS;
   endfunction
   // local wake arms on a falling edge and needs the low level to persist
   wire alertFall = alertPrev_ff & ~localAlert;
   wire nxt_wakeArmed = alertFall | (wakeArmed_ff & ~localAlert);
   lintmc_filter #(.LIMIT(16'(N_ENABLE))) uEn (
      .clock(clock), .nrst(nrst), .clkEn(clkEn), .active(modeSelect), .done(enHeld));
   lintmc_filter #(.LIMIT(16'(N_DISABLE))) uDis (
      .clock(clock), .nrst(nrst), .clkEn(clkEn), .active(~modeSelect), .done(disHeld));
   lintmc_filter #(.LIMIT(16'(N_WAKE))) uWake (
      .clock(clock), .nrst(nrst), .clkEn(clkEn), .active(wakeArmed_ff), .done(alertHeld));
   lintmc_filter #(.LIMIT(16'(N_LIN_WAKE))) uBus (
      .clock(clock), .nrst(nrst), .clkEn(clkEn), .active(busDominant), .done(busHeld));
   wire busRise = busPrev_ff & ~busDominant;
   wire busWake = busHeldLat_ff & busRise;
   wire localWake = alertHeld;
   // wakes count only in sleep or during the normal-to-sleep filter time
   wire inSleep = inState(state_ff, lintmc_pkg::ST_SLEEP);
   wire inDisFilt = inState(state_ff, lintmc_pkg::ST_NORMAL) & ~modeSelect;
   wire wakeWin = inSleep | inDisFilt;
   always_comb begin
      nxt_state = state_ff;
      nxt_wake = wake_ff;
      unique case (state_ff)
         lintmc_pkg::ST_UNPOWERED: begin
            nxt_state = lintmc_pkg::ST_STANDBY;
            nxt_wake = lintmc_pkg::WK_NONE;
         end
         lintmc_pkg::ST_STANDBY: begin
            if (enHeld)
               nxt_state = lintmc_pkg::ST_NORMAL;
         end
         lintmc_pkg::ST_NORMAL: begin
            if (wakeWin & (localWake | busWake)) begin
               nxt_state = lintmc_pkg::ST_STANDBY;
               nxt_wake = wakeSel(localWake);
            end else if (disHeld)
               nxt_state = lintmc_pkg::ST_SLEEP;
         end
         lintmc_pkg::ST_SLEEP: begin
            if (localWake | busWake) begin
               nxt_state = lintmc_pkg::ST_STANDBY;
               nxt_wake = wakeSel(localWake);
            end else if (enHeld) begin
               nxt_state = lintmc_pkg::ST_NORMAL;
               nxt_wake = lintmc_pkg::WK_NONE;
            end
         end
         default: nxt_state = lintmc_pkg::ST_UNPOWERED;
      endcase
      if (!batterySupplyOk) begin
         nxt_state = lintmc_pkg::ST_UNPOWERED;
         nxt_wake = lintmc_pkg::WK_NONE;
      end
   end
   // thermal recovery waits for a recessive transmit level to avoid oscillation
   wire nxt_txSeenHigh = thermalShutdown ? 1'b0 : (txSeenHigh_ff | txData);
   // host raising mode-select in standby releases the wake indication at once
   wire nxt_stbEnSeen = (nxt_state == lintmc_pkg::ST_STANDBY) & (stbEnSeen_ff | modeSelect);
   // dominant must outlast the filter; the latch keeps it until the rising edge
   wire nxt_busHeldLat = busDominant & (busHeld | busHeldLat_ff);
   // state and wake kind only move while the clock enable is high
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst)
         state_ff <= lintmc_pkg::ST_UNPOWERED;
      else if (clkEn)
         state_ff <= nxt_state;
   end
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst)
         wake_ff <= lintmc_pkg::WK_NONE;
      else if (clkEn)
         wake_ff <= nxt_wake;
   end
   // previous levels reset to the idle level so no false edge follows reset
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst)
         alertPrev_ff <= 1'b1;
      else if (clkEn)
         alertPrev_ff <= localAlert;
   end
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst)
         busPrev_ff <= 1'b0;
      else if (clkEn)
         busPrev_ff <= busDominant;
   end
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst)
         wakeArmed_ff <= 1'b0;
      else if (clkEn)
         wakeArmed_ff <= nxt_wakeArmed;
   end
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst)
         busHeldLat_ff <= 1'b0;
      else if (clkEn)
         busHeldLat_ff <= nxt_busHeldLat;
   end
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst)
         txSeenHigh_ff <= 1'b0;
      else if (clkEn)
         txSeenHigh_ff <= nxt_txSeenHigh;
   end
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst)
         stbEnSeen_ff <= 1'b0;
      else if (clkEn)
         stbEnSeen_ff <= nxt_stbEnSeen;
   end
   wire isStandby = inState(state_ff, lintmc_pkg::ST_STANDBY);
   wire isNormal = inState(state_ff, lintmc_pkg::ST_NORMAL);
   wire wakeInd = isStandby & (wake_ff != lintmc_pkg::WK_NONE) & ~stbEnSeen_ff;
   wire txEnable = isNormal & ~thermalShutdown & txSeenHigh_ff;
   // registered pin drives
   logic rxOe_ff, pdStrong_ff, drvDom_ff, term_ff, inh_ff;
   wire nxt_rxOe = (isNormal & busDominant) | wakeInd;
   wire nxt_pdStrong = wakeInd & (wake_ff == lintmc_pkg::WK_LOCAL);
   wire nxt_drvDom = txEnable & ~txData;
   wire nxt_term = isStandby | isNormal;
   wire nxt_inh = isStandby | isNormal;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst)
         rxOe_ff <= 1'b0;
      else if (clkEn)
         rxOe_ff <= nxt_rxOe;
   end
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst)
         pdStrong_ff <= lintmc_pkg::RST_PD_STRONG;
      else if (clkEn)
         pdStrong_ff <= nxt_pdStrong;
   end
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst)
         drvDom_ff <= 1'b0;
      else if (clkEn)
         drvDom_ff <= nxt_drvDom;
   end
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst)
         term_ff <= 1'b0;
      else if (clkEn)
         term_ff <= nxt_term;
   end
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst)
         inh_ff <= 1'b0;
      else if (clkEn)
         inh_ff <= nxt_inh;
   end
   assign rxDataOut = 1'b0;
   assign rxDataOe = rxOe_ff;
   assign txPullStrong = pdStrong_ff;
   assign busDriveDominant = drvDom_ff;
   assign busTermOn = term_ff;
   assign regulatorSwitchOut = inh_ff;
   assign opState = state_ff;
   assign wakeKind = wake_ff;
endmodule

// ### tb/lintmc_properties.sv
// checker: port assertions of the mode controller
`timescale 1ns/1ps
module lintmc_properties #(
   parameter int N_ENABLE = 4
) (
   // clocking and monitors
   input wire logic clock,
   input wire logic nrst,
   input wire logic batterySupplyOk,
   input wire logic thermalShutdown,
   input wire logic modeSelect,
   // pins and state
   input wire logic rxDataOe,
   input wire logic txPullStrong,
   input wire logic busDriveDominant,
   input wire logic regulatorSwitchOut,
   input wire logic [3:0] opState
);
   int hiCnt;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) hiCnt <= 0;
      else hiCnt <= modeSelect ? hiCnt + 1 : 0;
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   a_supply_low: assert property (!batterySupplyOk |=> opState == 4'h1)
      else $error("not unpowered after supply loss");
   a_unpow_quiet: assert property (opState == 4'h1 && $past(opState) == 4'h1
      |-> !(rxDataOe | txPullStrong | busDriveDominant | regulatorSwitchOut))
      else $error("unpowered outputs active");
   a_thermal_off: assert property (thermalShutdown && $past(thermalShutdown) |-> !busDriveDominant)
      else $error("transmitter on while overheated");
   a_standby_inh: assert property (opState == 4'h2 && $past(opState) == 4'h2
      |-> regulatorSwitchOut && !busDriveDominant)
      else $error("standby pins wrong");
   a_powerup_quiet: assert property (opState == 4'h2 && $past(opState) == 4'h1
      |=> !rxDataOe && !txPullStrong)
      else $error("power-up standby pins wrong");
   a_standby_fixed: assert property ((opState == 4'h2 && !modeSelect)[*4]
      |-> $stable(rxDataOe) && $stable(txPullStrong))
      else $error("standby pins changed");
   a_wake_ind: assert property (opState == 4'h2 && $past(opState) == 4'h8 |=> rxDataOe)
      else $error("no wake indication");
   a_normal_filt: assert property (opState == 4'h4 && $past(opState) != 4'h4
      |-> hiCnt >= N_ENABLE)
      else $error("normal entered too early");
endmodule
bind lintmc_top lintmc_properties #(.N_ENABLE(N_ENABLE)) u_props (.clock(clock), .nrst(nrst),
   .batterySupplyOk(batterySupplyOk), .thermalShutdown(thermalShutdown),
   .modeSelect(modeSelect), .rxDataOe(rxDataOe), .txPullStrong(txPullStrong),
   .busDriveDominant(busDriveDominant), .regulatorSwitchOut(regulatorSwitchOut),
   .opState(opState));

// ### tb/lintmc_bus_model.sv
// partner: the single-wire bus with its remote nodes
`timescale 1ns/1ps
module lintmc_bus_model (
   // our transmitter and remote nodes
   input wire logic driveDominant,
   input wire logic extDominant,
   // bus level seen
   output logic busDominant
);
   // any node pulling dominant wins
   assign busDominant = driveDominant | extDominant;
endmodule

// ### tb/tb_top.sv
// testbench: scenario tasks for the mode controller
`timescale 1ns/1ps
module tb_top;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic supplyOk = 1'b1;
   logic thermal = 1'b0;
   logic modeSel = 1'b0;
   logic txData = 1'b1;
   logic alert = 1'b1;
   logic extDom = 1'b0;
   logic rxOe, txStrong, drvDom, regSw, busDom, termOn, rxOut;
   logic [3:0] state;
   logic [1:0] wake;
   int failures = 0;
   int comparisons = 0;
   lintmc_top #(.N_ENABLE(4), .N_DISABLE(4), .N_WAKE(4), .N_LIN_WAKE(4)) u_dut (
      .clock(clock), .nrst(nrst), .clkEn(1'b1), .batterySupplyOk(supplyOk),
      .thermalShutdown(thermal), .modeSelect(modeSel), .txData(txData), .rxDataOut(rxOut),
      .rxDataOe(rxOe), .txPullStrong(txStrong), .localAlert(alert), .busDominant(busDom),
      .busDriveDominant(drvDom), .busTermOn(termOn), .regulatorSwitchOut(regSw),
      .opState(state), .wakeKind(wake));
   lintmc_bus_model u_bus (.driveDominant(drvDom), .extDominant(extDom), .busDominant(busDom));
   initial begin
      forever #12.5 clock = ~clock;
   end
   task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // pins packed as regulator, strong pull-down, receive low, transmitter
   task automatic pins(input logic [3:0] st, input logic [3:0] exp);
      chk(state, st);
      chk({regSw, txStrong, rxOe, drvDom}, exp);
   endtask
   task automatic end_of_test;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic t_normal;
      modeSel <= 1'b1;
      cyc(12);
      pins(4'h4, 4'h8);
      txData <= 1'b0;
      cyc(4);
      pins(4'h4, 4'hB);
      chk({3'h0, rxOut}, 4'h0);
      thermal <= 1'b1;
      cyc(4);
      pins(4'h4, 4'h8);
      thermal <= 1'b0;
      cyc(4);
      pins(4'h4, 4'h8);
      txData <= 1'b1;
      extDom <= 1'b1;
      cyc(4);
      pins(4'h4, 4'hA);
      extDom <= 1'b0;
      modeSel <= 1'b0;
      cyc(12);
      pins(4'h8, 4'h0);
      chk({3'h0, termOn}, 4'h0);
   endtask
   task automatic t_local;
      alert <= 1'b0;
      cyc(2);
      alert <= 1'b1;
      cyc(12);
      pins(4'h8, 4'h0);
      alert <= 1'b0;
      cyc(12);
      chk({2'h0, wake}, 4'h2);
      pins(4'h2, 4'hE);
      alert <= 1'b1;
      extDom <= 1'b1;
      cyc(8);
      extDom <= 1'b0;
      cyc(4);
      pins(4'h2, 4'hE);
   endtask
   task automatic t_bus;
      extDom <= 1'b1;
      cyc(8);
      extDom <= 1'b0;
      cyc(6);
      chk({2'h0, wake}, 4'h1);
      pins(4'h2, 4'hA);
      supplyOk <= 1'b0;
      cyc(3);
      pins(4'h1, 4'h0);
      chk({2'h0, termOn, rxOut}, 4'h0);
   endtask
   initial begin
      cyc(5);
      nrst <= 1'b1;
      cyc(4);
      pins(4'h2, 4'h8);
      chk({3'h0, termOn}, 4'h1);
      t_normal();
      t_local();
      t_normal();
      t_bus();
      end_of_test();
   end
   initial begin
      repeat (2000) @(posedge clock);
      failures++;
      end_of_test();
   end
endmodule
